// ==== fspa_align.sv ====
`timescale 1ns/1ps
`include "fspa_params.svh"
// Contract
// R01 - Frame mode: next clock rise after pulse aligns
// R02 - Rising pulse edge default, falling selectable
// R03 - Accept all listed pulse rates with clock
// R04 - Source keeps frame clock integer, under 150MHz
// R05 - Output clock and pulse integer related
// R06 - Frame outputs align to first clock rise
// R07 - Output pulse width selectable by duty, divider
// R08 - Pulse sync enable realigns output phase
// R09 - Sync mode: pulse edge itself aligns
// R10 - Source keeps sync clock integer, under 1GHz
// R11 - Sync mode edge rising default, falling selectable
// R12 - Sync output rate integer to input rate
// R13 - Any input and output selectable for pulses
// R14 - Oscillator input unmonitored, failure only inferred
// R15 - Synchronise pulse, registered edge detect event
module fspa_align
	import fspa_pkg::*;
#(
	parameter int NUM_IN = 8,
	parameter int NUM_OUT = 4,
	parameter int DIV_W = 16
)(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Wishbone classic slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Reference inputs from pins, asynchronous
	input wire logic [NUM_IN-1:0] ref_in_i,
	// Reference monitor failure flags per input
	input wire logic [NUM_IN-1:0] ref_fail_i,
	// Aligned output clock and generated output pulse
	output logic [NUM_OUT-1:0] aligned_output_clock_o,
	output logic [NUM_OUT-1:0] generated_output_pulse_o,
	// One-cycle alignment event
	output logic align_evt_o,
	// All monitored inputs down: oscillator failure suspected
	output logic osc_fail_infer_o
);

	// Registers
	logic [31:0] ctrl_r, ctrl_nxt;
	logic [31:0] sel_r, sel_nxt;
	logic [31:0] div_r, div_nxt;
	logic [31:0] duty_r, duty_nxt;
	logic ack_r, ack_nxt;
	logic [31:0] rdat_r, rdat_nxt;
	fspa_ctrl_s ctl;

	// Synchronisers for every input pin
	logic [NUM_IN-1:0] sync1_r, sync2_r, sync3_r;

	// Alignment state
	fspa_state_e state_r, state_nxt;
	logic [DIV_W-1:0] cnt_r, cnt_nxt;
	logic out_clk_r, out_clk_nxt;
	logic out_pls_r, out_pls_nxt;
	logic evt_r, evt_nxt;
	logic [7:0] align_cnt_r, align_cnt_nxt;
	logic osc_r, osc_nxt;

	// Selected pulse and clock inputs
	logic pls_cur, pls_prev, clk_cur, clk_prev;
	logic pls_edge, clk_rise;

	// Byte-lane merge, used for every writable register
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
		begin
			if (sel[i])
				r[i*8 +: 8] = nw[i*8 +: 8];
		end
		return r;
	endfunction

	assign ctl = fspa_ctrl_s'(ctrl_r[3:0]);

	// Register next values; write on the request cycle, ack one cycle
	always_comb
	begin
		ctrl_nxt = ctrl_r;
		sel_nxt = sel_r;
		div_nxt = div_r;
		duty_nxt = duty_r;
		ack_nxt = 1'b0;
		rdat_nxt = rdat_r;
		if (wb_cyc_i && wb_stb_i && !ack_r)
		begin
			ack_nxt = 1'b1;
			// Unmapped offsets read zero and ignore writes
			rdat_nxt = 32'h0000_0000;
			unique case (wb_adr_i)
				`FSPA_OFF_CTRL:
				begin
					rdat_nxt = {28'h0000000, ctrl_r[3:0]};
					if (wb_we_i)
						ctrl_nxt = merge(ctrl_r, wb_dat_i, wb_sel_i)
							& 32'h0000_000f;
				end
				`FSPA_OFF_SEL:
				begin
					// Any input for pulse and clock, any output (see R13)
					rdat_nxt = sel_r;
					if (wb_we_i)
						sel_nxt = merge(sel_r, wb_dat_i, wb_sel_i);
				end
				`FSPA_OFF_DIV:
				begin
					rdat_nxt = div_r;
					if (wb_we_i)
						div_nxt = merge(div_r, wb_dat_i, wb_sel_i);
				end
				`FSPA_OFF_DUTY:
				begin
					rdat_nxt = duty_r;
					if (wb_we_i)
						duty_nxt = merge(duty_r, wb_dat_i, wb_sel_i);
				end
				`FSPA_OFF_STAT:
					rdat_nxt = {20'h00000, osc_r, state_r, align_cnt_r,
						out_pls_r};
				`FSPA_OFF_MON:
					rdat_nxt = {{(32-NUM_IN){1'b0}}, ref_fail_i};
				default:
					rdat_nxt = 32'h0000_0000;
			endcase
		end
	end

	// Register bank
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ctrl_r <= `FSPA_CTRL_RST;
			sel_r <= 32'h0000_0000;
			div_r <= `FSPA_DIV_RST;
			duty_r <= `FSPA_DUTY_RST;
			ack_r <= 1'b0;
			rdat_r <= 32'h0000_0000;
		end
		else if (ce_i)
		begin
			ctrl_r <= ctrl_nxt;
			sel_r <= sel_nxt;
			div_r <= div_nxt;
			duty_r <= duty_nxt;
			ack_r <= ack_nxt;
			rdat_r <= rdat_nxt;
		end
	end

	assign wb_ack_o = ack_r;
	assign wb_dat_o = rdat_r;

	// Two flops into this domain, third flop for edge history (see R15)
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			sync1_r <= '0;
			sync2_r <= '0;
			sync3_r <= '0;
		end
		else if (ce_i)
		begin
			sync1_r <= ref_in_i;
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
		end
	end

	// Input selection; the first stage is never read here (see R13)
	always_comb
	begin
		pls_cur = sync2_r[sel_r[3:0] % NUM_IN];
		pls_prev = sync3_r[sel_r[3:0] % NUM_IN];
		clk_cur = sync2_r[sel_r[7:4] % NUM_IN];
		clk_prev = sync3_r[sel_r[7:4] % NUM_IN];
		// Polarity select on the pulse (see R02) (see R11)
		pls_edge = ctl.fall_edge ? (pls_prev && !pls_cur)
			: (!pls_prev && pls_cur);
		clk_rise = !clk_prev && clk_cur;
	end

	// Alignment machine and output divider
	// The divider counts this clock, so outputs are integer related (see R05)
	// Pulse rate is free: any edge spacing is accepted (see R03)
	always_comb
	begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		out_clk_nxt = out_clk_r;
		out_pls_nxt = out_pls_r;
		evt_nxt = 1'b0;
		align_cnt_nxt = align_cnt_r;
		// Not sticky; hardware sets it from the monitors every enabled cycle
		osc_nxt = &ref_fail_i; // see R14
		if (!ctl.enable)
		begin
			state_nxt = FSPA_IDLE;
		end
		else
		begin
			unique case (state_r)
				FSPA_IDLE:
					state_nxt = FSPA_RUN;
				FSPA_ARMED:
				begin
					// Frame mode waits for the next clock rise (see R01)
					if (clk_rise)
					begin
						cnt_nxt = '0; // see R06
						evt_nxt = 1'b1;
						align_cnt_nxt = align_cnt_r + 8'h01;
						state_nxt = FSPA_RUN;
					end
				end
				FSPA_RUN:
				begin
					if (cnt_r >= div_r[DIV_W-1:0] - DIV_W'(1))
						cnt_nxt = '0;
					else
						cnt_nxt = cnt_r + DIV_W'(1);
				end
				default:
					state_nxt = FSPA_IDLE;
			endcase
			// Realign only while sync of the output is enabled (see R08)
			if (pls_edge && ctl.pulse_sync_enable)
			begin
				if (ctl.sync_mode)
				begin
					// Pulse edge itself is the alignment edge (see R09)
					cnt_nxt = '0;
					evt_nxt = 1'b1;
					align_cnt_nxt = align_cnt_r + 8'h01;
					state_nxt = FSPA_RUN;
				end
				else
				begin
					state_nxt = FSPA_ARMED;
				end
			end
		end
		// Output clock is high for the first half of the period
		out_clk_nxt = ctl.enable &&
			(cnt_nxt < (div_r[DIV_W-1:0] >> 1));
		// Pulse width in clk_i cycles from the duty field (see R07)
		out_pls_nxt = ctl.enable && (cnt_nxt < duty_r[DIV_W-1:0]);
	end

	// Alignment state registers
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state_r <= FSPA_IDLE;
			cnt_r <= '0;
			out_clk_r <= 1'b0;
			out_pls_r <= 1'b0;
			evt_r <= 1'b0;
			align_cnt_r <= 8'h00;
			osc_r <= 1'b0;
		end
		else if (ce_i)
		begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			out_clk_r <= out_clk_nxt;
			out_pls_r <= out_pls_nxt;
			evt_r <= evt_nxt;
			align_cnt_r <= align_cnt_nxt;
			osc_r <= osc_nxt;
		end
	end

	// Route to the selected outputs (see R13)
	always_comb
	begin
		aligned_output_clock_o = '0;
		generated_output_pulse_o = '0;
		aligned_output_clock_o[sel_r[11:8] % NUM_OUT] = out_clk_r;
		generated_output_pulse_o[sel_r[15:12] % NUM_OUT] = out_pls_r;
	end

	assign align_evt_o = evt_r;
	assign osc_fail_infer_o = osc_r;

	// All properties below share this clock and this reset
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	// Single-cycle alignment event
	a_evt_one_cycle: assert property (evt_r && ce_i |=> !evt_r) // see R15
		else $error("alignment event longer than one cycle");
	// Frame mode event follows a clock rise in armed state
	a_frame_clk_align: assert property ( // see R01
		ce_i && state_r == FSPA_ARMED && clk_rise && ctl.enable
		&& !pls_edge |=> evt_r && cnt_r == '0)
		else $error("frame alignment missed clock rise");
	// Sync mode aligns on the pulse edge itself
	a_sync_edge: assert property ( // see R09
		ce_i && ctl.enable && ctl.sync_mode && ctl.pulse_sync_enable
		&& pls_edge |=> evt_r && cnt_r == '0)
		else $error("sync edge did not align");
	// No realignment while sync is off
	a_no_sync_off: assert property ( // see R08
		ce_i && !ctl.pulse_sync_enable && state_r != FSPA_ARMED
		|=> !evt_r)
		else $error("realigned with sync disabled");
	// Oscillator inference follows the monitors one cycle later
	a_osc_infer: assert property ( // see R14
		ce_i |=> osc_r == &$past(ref_fail_i))
		else $error("oscillator failure inference wrong");
	// Output pulse high after alignment when duty field is nonzero
	a_pulse_width: assert property ( // see R07
		ce_i && ctl.enable && evt_nxt && duty_r[DIV_W-1:0] != '0
		|=> out_pls_r)
		else $error("output pulse missing at alignment");
	// At most one lane of each output bus may be high
	a_route_one_lane: assert property ( // see R13
		$onehot0(aligned_output_clock_o) && $onehot0(generated_output_pulse_o))
		else $error("output routed to more than one lane");
	// Wishbone ack lasts exactly one cycle
	a_ack_pulse: assert property (ack_r && ce_i |=> !ack_r)
		else $error("ack held too long");
endmodule // fspa_align

// ==== fspa_params.svh ====
`ifndef FSPA_PARAMS_SVH
`define FSPA_PARAMS_SVH
// Register byte offsets on the Wishbone slave
`define FSPA_OFF_CTRL 8'h00
`define FSPA_OFF_SEL 8'h04
`define FSPA_OFF_DIV 8'h08
`define FSPA_OFF_DUTY 8'h0c
`define FSPA_OFF_STAT 8'h10
`define FSPA_OFF_MON 8'h14
// Control field positions
`define FSPA_CTRL_EN 0
`define FSPA_CTRL_SYNCMODE 1
`define FSPA_CTRL_FALL 2
`define FSPA_CTRL_PSYNC 3
// Reset values
`define FSPA_CTRL_RST 32'h0000_0000
`define FSPA_DIV_RST 32'h0000_0008
`define FSPA_DUTY_RST 32'h0000_0001
// Least pulse width at the reference input and clk_i period, in ns
`define FSPA_MIN_PULSE_NS 10
`define FSPA_CLK_NS 8
`endif

// ==== fspa_pkg.sv ====
package fspa_pkg;
	// Alignment state of the channel
	typedef enum logic [1:0] {FSPA_IDLE, FSPA_ARMED, FSPA_RUN} fspa_state_e;
	// Wishbone request carrier
	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [3:0] sel;
		logic [7:0] adr;
		logic [31:0] dat;
	} fspa_wb_req_s;
	// Control fields
	typedef struct packed {
		logic pulse_sync_enable;
		logic fall_edge;
		logic sync_mode;
		logic enable;
	} fspa_ctrl_s;
endpackage

// ==== fspa_src.sv ====
`timescale 1ns/1ps
// Upstream timing source: a free running associated clock plus pulses
module fspa_src (
	output logic link_clk_o,
	output logic pulse_o
);
	// Time of the last rising pulse edge, read by the bench
	realtime t_edge;
	// Reference clocks run free, so this one never stops between pulses
	initial
	begin
		link_clk_o = 1'b0;
		pulse_o = 1'b0;
		t_edge = 0;
		#5.3;
		forever #32 link_clk_o = ~link_clk_o;
	end
	// One pulse of 48 ns, well above the least width, launched at a
	// clock fall so the next clock rise is 32 ns later
	task automatic send_pulse();
		@(negedge link_clk_o);
		pulse_o = 1'b1;
		t_edge = $realtime;
		#48 pulse_o = 1'b0;
	endtask
endmodule // fspa_src

// ==== tb_top.sv ====
`timescale 1ns/1ps
`include "fspa_params.svh"
module tb_top;
	import fspa_pkg::*;
	logic clk_i, rst_i, ce, ack, evt, osc, s_clk, s_pls, p_at_evt, in_win;
	fspa_wb_req_s req; // Bus request carrier
	logic [31:0] rdat, q;
	logic [7:0] ref_in, ref_fail;
	logic [3:0] oclk, opls;
	int pi, ci, n_evt, n0, cyc_cnt, n_mismatch, checked, c_p, c_c;
	realtime t_evt, d;
	// Modes: sync rise, sync fall, frame rise, frame fall
	logic [31:0] ctl [4] = '{32'h0b, 32'h0f, 32'h09, 32'h0d};
	// Edge to seen-event windows in ns, one clock of sampling included
	int lo [4] = '{16, 64, 48, 120};
	int hi [4] = '{48, 104, 96, 160};
	fspa_align fspa_align_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
		.wb_cyc_i(req.cyc), .wb_stb_i(req.stb), .wb_we_i(req.we),
		.wb_sel_i(req.sel), .wb_adr_i(req.adr), .wb_dat_i(req.dat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .ref_in_i(ref_in),
		.ref_fail_i(ref_fail), .aligned_output_clock_o(oclk),
		.generated_output_pulse_o(opls), .align_evt_o(evt),
		.osc_fail_infer_o(osc));
	fspa_src fspa_src_i (.link_clk_o(s_clk), .pulse_o(s_pls));
	// Route the source onto whichever pins the test selected
	always_comb ref_in = (8'(s_clk) << ci) | (8'(s_pls) << pi);
	initial
	begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end
	// Record each alignment event and the pulse output beside it
	always @(posedge clk_i)
	begin
		cyc_cnt++;
		if (evt === 1'b1)
		begin
			n_evt++;
			t_evt = $realtime;
			p_at_evt = opls[2];
		end
		if (cyc_cnt == 5000)
		begin
			n_mismatch++;
			complete_run();
		end
	end
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		checked++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("mismatch %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	// Classic cycle: hold until ack is sampled high, then release
	task automatic wb(input logic we, input logic [7:0] a,
		input logic [31:0] w);
		int n;
		n = 0;
		@(posedge clk_i);
		req <= '{1'b1, 1'b1, we, 4'hf, a, w};
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (ack !== 1'b1 && n < 50);
		q = rdat;
		req <= '0;
		if (n >= 50)
		begin
			// A slave that never answers ends the run as a failure
			chk("wb_ack", 32'h0, 32'h1);
			complete_run();
		end
	endtask
	task automatic rdc(input string nm, input logic [7:0] a,
		input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		chk(nm, q, e);
	endtask
	task automatic complete_run();
		if (n_mismatch == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial
	begin
		req = '0;
		ce = 1'b1;
		rst_i = 1'b1;
		ref_fail = 8'h00;
		{pi, ci, n_evt, cyc_cnt, n_mismatch, checked} = {32'd0, 32'd1, 128'd0};
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		rdc("ctrl_rst", `FSPA_OFF_CTRL, `FSPA_CTRL_RST);
		rdc("div_rst", `FSPA_OFF_DIV, `FSPA_DIV_RST);
		rdc("duty_rst", `FSPA_OFF_DUTY, `FSPA_DUTY_RST);
		wb(1'b1, 8'h18, 32'hffff_ffff);
		rdc("unmapped", 8'h18, 32'h0);
		wb(1'b1, `FSPA_OFF_CTRL, 32'hff);
		rdc("ctrl_bits", `FSPA_OFF_CTRL, 32'h0f);
		wb(1'b1, `FSPA_OFF_DUTY, 32'h3);
		wb(1'b1, `FSPA_OFF_SEL, 32'h2110);
		// Without pulse sync enabled a pulse must not realign
		wb(1'b1, `FSPA_OFF_CTRL, 32'h1);
		repeat (8) @(posedge clk_i);
		n0 = n_evt;
		fspa_src_i.send_pulse();
		repeat (30) @(posedge clk_i);
		chk("evt_gated", 32'(n_evt - n0), 32'h0);
		for (int k = 0; k < 4; k++)
		begin
			// Last mode also moves both inputs to other pins
			if (k == 3)
			begin
				pi = 5;
				ci = 3;
				wb(1'b1, `FSPA_OFF_SEL, 32'h2135);
			end
			wb(1'b1, `FSPA_OFF_CTRL, ctl[k]);
			// Let any edge from the mode change settle before counting
			repeat (8) @(posedge clk_i);
			n0 = n_evt;
			fspa_src_i.send_pulse();
			repeat (30) @(posedge clk_i);
			d = t_evt - fspa_src_i.t_edge;
			in_win = d >= lo[k] && d <= hi[k];
			chk("evt_count", 32'(n_evt - n0), 32'h1);
			chk("evt_delay", 32'(in_win), 32'h1);
			chk("pulse_at_evt", {31'h0, p_at_evt}, 32'h1);
		end
		// Width of pulse and clock over two output periods of 8 cycles
		{c_p, c_c} = '0;
		repeat (16)
		begin
			@(posedge clk_i);
			c_p += opls[2];
			c_c += oclk[1];
			chk("others", {28'h0, (opls & 4'hb) | (oclk & 4'hd)}, 32'h0);
		end
		chk("pulse_width", 32'(c_p), 32'd6);
		chk("clock_high", 32'(c_c), 32'd8);
		// Four alignments so far, machine running, no oscillator flag
		wb(1'b0, `FSPA_OFF_STAT, 32'h0);
		chk("stat", q & 32'hffff_fffe, 32'h0000_0408);
		// Clock enable low must hold the clock and pulse outputs where they stand
		ce <= 1'b0;
		@(posedge clk_i);
		q = {24'h00_0000, oclk, opls};
		repeat (5) @(posedge clk_i);
		chk("ce_freeze", {24'h00_0000, oclk, opls}, q);
		ce <= 1'b1;
		ref_fail <= 8'hff;
		repeat (3) @(posedge clk_i);
		chk("osc_infer", {31'h0, osc}, 32'h1);
		rdc("mon", `FSPA_OFF_MON, 32'hff);
		ref_fail <= 8'hfe;
		repeat (3) @(posedge clk_i);
		chk("osc_part", {31'h0, osc}, 32'h0);
		complete_run();
	end
endmodule // tb_top
